// File: pcmux_pkg.sv
package pcmux_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NPIN = 3;

  // byte addresses of the register words
  localparam logic [7:0] OFS_LEVELS = 8'h00;
  localparam logic [7:0] OFS_LATCH = 8'h04;
  localparam logic [7:0] OFS_DIR = 8'h08;
  localparam logic [7:0] OFS_ANS_LOW = 8'h0C;
  localparam logic [7:0] OFS_ANS_HIGH = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // reset values
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] ANS_LOW_RST = 8'hF8;
  localparam logic [7:0] ANS_HIGH_RST = 8'h0F;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // implemented bits of the analog select and control words
  localparam logic [7:0] ANS_LOW_MASK = 8'hF8;
  localparam logic [7:0] ANS_HIGH_MASK = 8'h0F;
  localparam logic [7:0] CTRL_MASK = 8'h01;

  // field positions
  localparam int PIN_BASE_BIT = 5;
  localparam int PIN5_IDX = 0;
  localparam int PIN6_IDX = 1;
  localparam int PIN7_IDX = 2;
  localparam int ANS_PIN6_BIT = 0;
  localparam int ANS_PIN7_BIT = 1;
  localparam int CTRL_SHDN_TRI_BIT = 0;
  localparam int STAT_OE_LSB = 0;
  localparam int STAT_OSC_BIT = 3;
  localparam int STAT_SHDN_BIT = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    REG_LEVELS = 3'b000,
    REG_LATCH = 3'b001,
    REG_DIR = 3'b010,
    REG_ANS_LOW = 3'b011,
    REG_ANS_HIGH = 3'b100,
    REG_CTRL = 3'b101,
    REG_STATUS = 3'b110,
    REG_NONE = 3'b111
  } pcmux_reg_t;

  // signals from the peripherals that share the pins
  typedef struct packed {
    logic ccp_drive_en;
    logic compare_pwm_signal;
    logic pwm_a_en;
    logic pwm_channel_a;
    logic pwm_shutdown;
    logic timer_osc_en;
    logic sdo_en;
    logic sdo_out;
  } pcmux_periph_in_t;

  // digital inputs handed to the peripherals
  typedef struct packed {
    logic timer0_ext_clock_in;
    logic timer1_3_ext_clock_in;
    logic slave_select_in;
    logic capture_in;
    logic analog_channel_8_en;
    logic analog_channel_9_en;
    logic timer_osc_active;
  } pcmux_periph_out_t;

endpackage : pcmux_pkg

// File: pcmux_sync.sv
module pcmux_sync #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage3_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end else begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // a bit moves only once the last two stages agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!resetn) begin
          level_out[i] <= 1'b0;
        end else if (stage2_r[i] == stage3_r[i]) begin
          level_out[i] <= stage3_r[i];
        end
      end
    end
  endgenerate

endmodule : pcmux_sync

// File: pcmux_pindrv.sv
module pcmux_pindrv (
  input wire logic clk,
  input wire logic resetn,
  input wire logic kill,
  input wire logic own_en,
  input wire logic own_val,
  input wire logic dir,
  input wire logic latch,
  output logic pin_out,
  output logic pin_oe
);

  // analog select never reaches this driver
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else if (kill) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else if (dir) begin
      pin_out <= latch;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= own_en ? own_val : latch;
      pin_oe <= 1'b1;
    end
  end

endmodule : pcmux_pindrv

// File: pcmux_top.sv
// Behaviour
// - pin 5 output, direction clear: compare/PWM signal replaces latch value when driving
// - pin 5 carries PWM channel A over port data; tri-stated on shutdown if enabled
// - timer oscillator enabled: pins 6 and 7 lose digital input and output
// - pin 7 output, direction clear: serial data output beats the latch value
// - pin 6 input feeds the serial slave-select input
// - pin 5 input clocks timer 0; pin 6 input clocks timers 1 and 3
// - pins 6 and 7 set as inputs serve analog channels 8 and 9
// - analog-select set: digital input off, reads give zero, analog still works
// - analog select leaves digital output alone; output pin still drives
// - analog select changes only the input path of its pin
module pcmux_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  input wire pcmux_pkg::pcmux_periph_in_t periph_in,
  output pcmux_pkg::pcmux_periph_out_t periph_out
);

  function automatic pcmux_pkg::pcmux_reg_t reg_decode(input logic [7:0] addr);
    case (addr)
      pcmux_pkg::OFS_LEVELS: reg_decode = pcmux_pkg::REG_LEVELS;
      pcmux_pkg::OFS_LATCH: reg_decode = pcmux_pkg::REG_LATCH;
      pcmux_pkg::OFS_DIR: reg_decode = pcmux_pkg::REG_DIR;
      pcmux_pkg::OFS_ANS_LOW: reg_decode = pcmux_pkg::REG_ANS_LOW;
      pcmux_pkg::OFS_ANS_HIGH: reg_decode = pcmux_pkg::REG_ANS_HIGH;
      pcmux_pkg::OFS_CTRL: reg_decode = pcmux_pkg::REG_CTRL;
      pcmux_pkg::OFS_STATUS: reg_decode = pcmux_pkg::REG_STATUS;
      default: reg_decode = pcmux_pkg::REG_NONE;
    endcase
  endfunction : reg_decode

  function automatic logic reg_hit(input logic go, input pcmux_pkg::pcmux_reg_t sel,
                                   input pcmux_pkg::pcmux_reg_t want);
    reg_hit = go & (sel == want);
  endfunction : reg_hit

  logic [7:0] latch_r;
  logic [7:0] dir_r;
  logic [7:0] ans_low_r;
  logic [7:0] ans_high_r;
  logic [7:0] ctrl_r;

  logic [7:0] aw_addr_r;
  logic aw_got_r;
  logic [7:0] w_data_r;
  logic w_lane0_r;
  logic w_got_r;

  logic [2:0] pin_lvl;
  logic [2:0] ans_gate;
  logic [2:0] dig_en;
  logic [2:0] pin_dig;
  logic [2:0] kill;
  logic [2:0] own_en;
  logic [2:0] own_val;
  logic [2:0] pin_dir;
  logic [2:0] pin_latch;
  logic shdn_tri;
  logic do_write;
  logic wr_go;
  pcmux_pkg::pcmux_reg_t wr_reg;
  pcmux_pkg::pcmux_reg_t rd_reg;
  logic [7:0] rd_byte;

  pcmux_sync #(
    .W(pcmux_pkg::NPIN)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(pin_in),
    .level_out(pin_lvl)
  );

  // input gating: pin 5 has no analog function, so no select bit
  assign ans_gate[pcmux_pkg::PIN5_IDX] = 1'b0;
  assign ans_gate[pcmux_pkg::PIN6_IDX] = ans_high_r[pcmux_pkg::ANS_PIN6_BIT];
  assign ans_gate[pcmux_pkg::PIN7_IDX] = ans_high_r[pcmux_pkg::ANS_PIN7_BIT];
  assign dig_en[pcmux_pkg::PIN5_IDX] = ~ans_gate[pcmux_pkg::PIN5_IDX];
  assign dig_en[pcmux_pkg::PIN6_IDX] = ~ans_gate[pcmux_pkg::PIN6_IDX]
                                     & ~periph_in.timer_osc_en;
  assign dig_en[pcmux_pkg::PIN7_IDX] = ~ans_gate[pcmux_pkg::PIN7_IDX]
                                     & ~periph_in.timer_osc_en;
  assign pin_dig = pin_lvl & dig_en;

  assign pin_dir = dir_r[pcmux_pkg::PIN_BASE_BIT +: pcmux_pkg::NPIN];
  assign pin_latch = latch_r[pcmux_pkg::PIN_BASE_BIT +: pcmux_pkg::NPIN];

  // output ownership per pin
  assign shdn_tri = ctrl_r[pcmux_pkg::CTRL_SHDN_TRI_BIT];
  assign kill[pcmux_pkg::PIN5_IDX] = periph_in.pwm_a_en & periph_in.pwm_shutdown
                                   & shdn_tri;
  assign kill[pcmux_pkg::PIN6_IDX] = periph_in.timer_osc_en;
  assign kill[pcmux_pkg::PIN7_IDX] = periph_in.timer_osc_en;

  // enhanced channel A takes precedence over plain compare output
  assign own_en[pcmux_pkg::PIN5_IDX] = periph_in.pwm_a_en | periph_in.ccp_drive_en;
  assign own_val[pcmux_pkg::PIN5_IDX] = periph_in.pwm_a_en ? periph_in.pwm_channel_a
                                      : periph_in.compare_pwm_signal;
  assign own_en[pcmux_pkg::PIN6_IDX] = 1'b0;
  assign own_val[pcmux_pkg::PIN6_IDX] = 1'b0;
  assign own_en[pcmux_pkg::PIN7_IDX] = periph_in.sdo_en;
  assign own_val[pcmux_pkg::PIN7_IDX] = periph_in.sdo_out;

  genvar p;
  generate
    for (p = 0; p < pcmux_pkg::NPIN; p++) begin : g_pin
      pcmux_pindrv u_drv (
        .clk(clk),
        .resetn(resetn),
        .kill(kill[p]),
        .own_en(own_en[p]),
        .own_val(own_val[p]),
        .dir(pin_dir[p]),
        .latch(pin_latch[p]),
        .pin_out(pin_out[p]),
        .pin_oe(pin_oe[p])
      );
    end
  endgenerate

  // pin-fed peripheral inputs need the direction bit set; timer_osc_active follows timer_osc_en alone
  always_ff @(posedge clk) begin
    if (!resetn) begin
      periph_out <= '0;
    end else begin
      periph_out.timer0_ext_clock_in <= pin_dir[pcmux_pkg::PIN5_IDX]
                                      & pin_dig[pcmux_pkg::PIN5_IDX];
      periph_out.capture_in <= pin_dir[pcmux_pkg::PIN5_IDX] & pin_dig[pcmux_pkg::PIN5_IDX];
      periph_out.timer1_3_ext_clock_in <= pin_dir[pcmux_pkg::PIN6_IDX]
                                        & pin_dig[pcmux_pkg::PIN6_IDX];
      periph_out.slave_select_in <= pin_dir[pcmux_pkg::PIN6_IDX]
                                  & pin_dig[pcmux_pkg::PIN6_IDX];
      // analog channels ignore the select bits, only the input gate moves
      periph_out.analog_channel_8_en <= pin_dir[pcmux_pkg::PIN6_IDX]
                                      & ~periph_in.timer_osc_en;
      periph_out.analog_channel_9_en <= pin_dir[pcmux_pkg::PIN7_IDX]
                                      & ~periph_in.timer_osc_en;
      periph_out.timer_osc_active <= periph_in.timer_osc_en;
    end
  end

  // write address and data are caught separately, in either order
  always_ff @(posedge clk) begin
    if (!resetn) begin
      awready <= 1'b0;
      aw_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else begin
      awready <= awvalid & ~awready & ~aw_got_r & ~bvalid;
      if (awvalid & awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= awaddr;
      end else if (do_write) begin
        aw_got_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wready <= 1'b0;
      w_got_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane0_r <= 1'b0;
    end else begin
      wready <= wvalid & ~wready & ~w_got_r & ~bvalid;
      if (wvalid & wready) begin
        w_got_r <= 1'b1;
        w_data_r <= wdata[7:0];
        w_lane0_r <= wstrb[0];
      end else if (do_write) begin
        w_got_r <= 1'b0;
      end
    end
  end

  assign do_write = aw_got_r & w_got_r & ~bvalid;
  assign wr_reg = reg_decode(aw_addr_r);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bvalid <= 1'b0;
      bresp <= pcmux_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= (wr_reg == pcmux_pkg::REG_NONE) ? pcmux_pkg::RESP_SLVERR
             : pcmux_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // only byte lane 0 carries register bits; other lanes are ignored
  assign wr_go = do_write & w_lane0_r;

  // the pin levels word is port data, so writing it lands in the latch
  always_ff @(posedge clk) begin
    if (!resetn) begin
      latch_r <= pcmux_pkg::LATCH_RST;
    end else if (reg_hit(wr_go, wr_reg, pcmux_pkg::REG_LEVELS)
                 | reg_hit(wr_go, wr_reg, pcmux_pkg::REG_LATCH)) begin
      latch_r <= w_data_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      dir_r <= pcmux_pkg::DIR_RST;
    end else if (reg_hit(wr_go, wr_reg, pcmux_pkg::REG_DIR)) begin
      dir_r <= w_data_r;
    end
  end

  // unimplemented select bits stay zero; of the kept bits only ans_high_r bits 0 and 1 gate a pin input
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ans_low_r <= pcmux_pkg::ANS_LOW_RST;
    end else if (reg_hit(wr_go, wr_reg, pcmux_pkg::REG_ANS_LOW)) begin
      ans_low_r <= w_data_r & pcmux_pkg::ANS_LOW_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ans_high_r <= pcmux_pkg::ANS_HIGH_RST;
    end else if (reg_hit(wr_go, wr_reg, pcmux_pkg::REG_ANS_HIGH)) begin
      ans_high_r <= w_data_r & pcmux_pkg::ANS_HIGH_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_r <= pcmux_pkg::CTRL_RST;
    end else if (reg_hit(wr_go, wr_reg, pcmux_pkg::REG_CTRL)) begin
      ctrl_r <= w_data_r & pcmux_pkg::CTRL_MASK;
    end
  end

  assign rd_reg = reg_decode(araddr);

  always_comb begin
    rd_byte = 8'h00;
    case (rd_reg)
      // bits below the upper pins belong to other logic and read as zero
      pcmux_pkg::REG_LEVELS: rd_byte = {pin_dig, 5'h00};
      pcmux_pkg::REG_LATCH: rd_byte = latch_r;
      pcmux_pkg::REG_DIR: rd_byte = dir_r;
      pcmux_pkg::REG_ANS_LOW: rd_byte = ans_low_r;
      pcmux_pkg::REG_ANS_HIGH: rd_byte = ans_high_r;
      pcmux_pkg::REG_CTRL: rd_byte = ctrl_r;
      pcmux_pkg::REG_STATUS: begin
        rd_byte[pcmux_pkg::STAT_OE_LSB +: pcmux_pkg::NPIN] = pin_oe;
        rd_byte[pcmux_pkg::STAT_OSC_BIT] = periph_in.timer_osc_en;
        rd_byte[pcmux_pkg::STAT_SHDN_BIT] = periph_in.pwm_shutdown;
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // one read in flight: no new address while data still waits
  always_ff @(posedge clk) begin
    if (!resetn) begin
      arready <= 1'b0;
    end else begin
      arready <= arvalid & ~arready & ~rvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= pcmux_pkg::RESP_OKAY;
    end else begin
      if (arvalid & arready) begin
        rvalid <= 1'b1;
        rdata <= {24'h000000, rd_byte};
        rresp <= (rd_reg == pcmux_pkg::REG_NONE) ? pcmux_pkg::RESP_SLVERR
               : pcmux_pkg::RESP_OKAY;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule : pcmux_top

// File: pcmux_chk.sv
module pcmux_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire pcmux_pkg::pcmux_periph_in_t periph_in,
  input wire pcmux_pkg::pcmux_periph_out_t periph_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  aw_pulse_a: assert property (awready |=> !awready)
    else $error("awready held past one cycle");
  // both halves are held one edge after the handshake, bvalid rises the edge after that
  wr_resp_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  b_done_a: assert property (bvalid && bready |=> !bvalid)
    else $error("bvalid kept after handshake");
  rd_resp_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  osc_oe_a: assert property (periph_in.timer_osc_en |=> pin_oe[2:1] == 2'b00)
    else $error("pins 6 and 7 driven while oscillator on");
  osc_ana_a: assert property (periph_in.timer_osc_en |=>
    !periph_out.analog_channel_8_en && !periph_out.analog_channel_9_en)
    else $error("analog inputs kept while oscillator on");
  pwm_drive_a: assert property (pin_oe[0] && $past(periph_in.pwm_a_en) |->
    pin_out[0] == $past(periph_in.pwm_channel_a))
    else $error("pin 5 not carrying pwm channel");
  ccp_drive_a: assert property (pin_oe[0] && $past(periph_in.ccp_drive_en) &&
    !$past(periph_in.pwm_a_en) |-> pin_out[0] == $past(periph_in.compare_pwm_signal))
    else $error("pin 5 not carrying compare signal");
  sdo_drive_a: assert property (pin_oe[2] && $past(periph_in.sdo_en) |->
    pin_out[2] == $past(periph_in.sdo_out))
    else $error("pin 7 not carrying serial output");
  ana8_in_a: assert property (periph_out.analog_channel_8_en |-> !pin_oe[1])
    else $error("analog channel 8 on a driven pin");
  ana9_in_a: assert property (periph_out.analog_channel_9_en |-> !pin_oe[2])
    else $error("analog channel 9 on a driven pin");
endmodule : pcmux_chk

bind pcmux_top pcmux_chk u_chk (.clk(clk), .resetn(resetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .pin_out(pin_out),
  .pin_oe(pin_oe), .periph_in(periph_in), .periph_out(periph_out));

// File: tb_pcmux_top.sv
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end

module tb_pcmux_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, resetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] pin_in = 3'h0;
  logic [2:0] pin_out, pin_oe;
  pcmux_pkg::pcmux_periph_in_t periph_in = '0;
  pcmux_pkg::pcmux_periph_out_t periph_out;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  logic [7:0] rst_a [6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [7:0] rst_v [6] = '{8'h00, 8'hFF, 8'hF8, 8'h0F, 8'h00, 8'h00};

  pcmux_top u_dut (.clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_in(periph_in),
    .periph_out(periph_out));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] ev, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    `CHK(rresp, er)
    if (er === pcmux_pkg::RESP_OKAY) `CHK(rdata, {24'h0, ev})
  endtask : rd

  // input synchroniser needs several edges to settle
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask : settle

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(rst_a[i], rst_v[i], pcmux_pkg::RESP_OKAY);
    rd(8'h1C, 8'h00, pcmux_pkg::RESP_SLVERR);
    wr(8'h20, 8'h55, pcmux_pkg::RESP_SLVERR);
    wr(pcmux_pkg::OFS_ANS_LOW, 8'hFF, pcmux_pkg::RESP_OKAY);
    rd(pcmux_pkg::OFS_ANS_LOW, 8'hF8, pcmux_pkg::RESP_OKAY);
    wr(pcmux_pkg::OFS_LATCH, 8'hA0, pcmux_pkg::RESP_OKAY);
    wr(pcmux_pkg::OFS_DIR, 8'h00, pcmux_pkg::RESP_OKAY);
    settle();
    `CHK(pin_out, 3'b101)
    `CHK(pin_oe, 3'b111)
    wr(pcmux_pkg::OFS_LEVELS, 8'h40, pcmux_pkg::RESP_OKAY);
    rd(pcmux_pkg::OFS_LATCH, 8'h40, pcmux_pkg::RESP_OKAY);
    wr(pcmux_pkg::OFS_ANS_HIGH, 8'h03, pcmux_pkg::RESP_OKAY);
    settle();
    `CHK(pin_out, 3'b010)
    `CHK(pin_oe, 3'b111)
    pin_in <= 3'b111;
    wr(pcmux_pkg::OFS_DIR, 8'hFF, pcmux_pkg::RESP_OKAY);
    settle();
    `CHK(pin_oe, 3'b000)
    rd(pcmux_pkg::OFS_LEVELS, 8'h20, pcmux_pkg::RESP_OKAY);
    `CHK({periph_out.timer0_ext_clock_in, periph_out.slave_select_in}, 2'b10)
    `CHK(periph_out.capture_in, 1'b1)
    `CHK(periph_out.timer1_3_ext_clock_in, 1'b0)
    `CHK({periph_out.analog_channel_8_en, periph_out.analog_channel_9_en}, 2'b11)
    wr(pcmux_pkg::OFS_ANS_HIGH, 8'h00, pcmux_pkg::RESP_OKAY);
    settle();
    rd(pcmux_pkg::OFS_LEVELS, 8'hE0, pcmux_pkg::RESP_OKAY);
    `CHK(periph_out.slave_select_in, 1'b1)
    `CHK(periph_out.timer1_3_ext_clock_in, 1'b1)
    pin_in <= 3'b000;
    settle();
    rd(pcmux_pkg::OFS_LEVELS, 8'h00, pcmux_pkg::RESP_OKAY);
    `CHK(periph_out.timer0_ext_clock_in, 1'b0)
    pin_in <= 3'b111;
    periph_in.timer_osc_en <= 1'b1;
    wr(pcmux_pkg::OFS_DIR, 8'h00, pcmux_pkg::RESP_OKAY);
    settle();
    `CHK(pin_oe, 3'b001)
    `CHK(periph_out.timer_osc_active, 1'b1)
    rd(pcmux_pkg::OFS_LEVELS, 8'h20, pcmux_pkg::RESP_OKAY);
    rd(pcmux_pkg::OFS_STATUS, 8'h09, pcmux_pkg::RESP_OKAY);
    periph_in.timer_osc_en <= 1'b0;
    wr(pcmux_pkg::OFS_LATCH, 8'h20, pcmux_pkg::RESP_OKAY);
    periph_in.ccp_drive_en <= 1'b1;
    settle();
    `CHK(pin_out[0], 1'b0)
    periph_in.compare_pwm_signal <= 1'b1;
    settle();
    `CHK(pin_out[0], 1'b1)
    // channel A low while latch and compare are high, so only the pwm path gives 0
    periph_in.pwm_a_en <= 1'b1;
    periph_in.pwm_channel_a <= 1'b0;
    periph_in.pwm_shutdown <= 1'b1;
    settle();
    `CHK({pin_oe[0], pin_out[0]}, 2'b10)
    wr(pcmux_pkg::OFS_CTRL, 8'h01, pcmux_pkg::RESP_OKAY);
    settle();
    `CHK(pin_oe[0], 1'b0)
    periph_in.pwm_shutdown <= 1'b0;
    periph_in.sdo_en <= 1'b1;
    periph_in.sdo_out <= 1'b1;
    settle();
    `CHK(pin_oe[0], 1'b1)
    `CHK({pin_oe[2], pin_out[2]}, 2'b11)
    wr(pcmux_pkg::OFS_DIR, 8'hFF, pcmux_pkg::RESP_OKAY);
    settle();
    `CHK(pin_oe, 3'b000)
    wrap_up();
  end
endmodule : tb_pcmux_top
